// *** rtl/ardio_pcnt.sv ***
`timescale 1ns/1ps
// =====================================================================
// Pulse frequency counter: one pin, one-second gate
// =====================================================================
module ardio_pcnt
  import ardio_pkg::*;
#(
  parameter int FW = ARD_FW
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic pin,
  input wire logic en,
  input wire logic gate,
  output logic [FW-1:0] freq
);

  typedef struct packed {
    logic [2:0] sy;
    logic lvl;
    logic [FW-1:0] cnt;
    logic [FW-1:0] frq;
  } ardio_pc_st_t;

  ardio_pc_st_t q, d;
  logic rise;

  // Sync, edge count, latch at gate end
  always_comb
  begin
    d = q;
    d.sy = {q.sy[1:0], pin};
    if (q.sy[1] == q.sy[2])
      d.lvl = q.sy[1];
    rise = d.lvl && !q.lvl;
    if (rise && q.cnt != '1)
      d.cnt = q.cnt + 1'b1;
    if (gate)
    begin
      d.frq = (rise && q.cnt != '1) ? q.cnt + 1'b1 : q.cnt;
      d.cnt = '0;
    end
    if (!en)
    begin
      d.cnt = '0;
      d.frq = '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      q <= '0;
    else
      q <= d;
  end

  assign freq = q.frq;

  // =================================================================
  // Checks
  // =================================================================
  property p_frq_hold;
    @(posedge clk) disable iff (!rstn)
    (!gate && en) |=> $stable(freq);
  endproperty
  a_frq_hold: assert property (p_frq_hold) else $error("freq moved off gate");

  property p_frq_clr;
    @(posedge clk) disable iff (!rstn)
    !en |=> (freq == '0);
  endproperty
  a_frq_clr: assert property (p_frq_clr) else $error("disabled counter not clear");

endmodule : ardio_pcnt

// *** rtl/ardio_pkg.sv ***
// =====================================================================
// Alarm relay and digital IO channel logic: shared constants
// =====================================================================
package ardio_pkg;

  // =================================================================
  // Sizes and timing
  // =================================================================
  localparam int ARD_NCH = 16;
  localparam int ARD_DW = 16;
  localparam int ARD_AW = 8;
  localparam int ARD_FW = 16;
  localparam int ARD_NPL = 4;
  localparam int ARD_CLK_NS = 100;
  localparam int ARD_TICK_NS = 100_000_000;
  localparam int ARD_TICK_CYC = ARD_TICK_NS / ARD_CLK_NS;
  localparam int ARD_GATE_NS = 1_000_000_000;
  localparam int ARD_GATE_TICKS = ARD_GATE_NS / ARD_TICK_NS;
  localparam logic [15:0] ARD_DUR_MIN = 16'h0001;
  localparam logic [15:0] ARD_DUR_MAX = 16'hfd20;

  // =================================================================
  // Card population
  // =================================================================
  localparam int ARD_CH_DIG8 = 8;
  localparam int ARD_CH_DIG16 = 16;
  localparam int ARD_CH_REL4 = 4;
  localparam int ARD_CH_REL8 = 8;
  localparam int ARD_REL8_FIXED = 6;

  // =================================================================
  // Register map (word index)
  // =================================================================
  localparam logic [7:0] A_CARD = 8'h00;
  localparam logic [7:0] A_STATE = 8'h01;
  localparam logic [7:0] A_RELAY = 8'h02;
  localparam logic [7:0] A_ISTAT = 8'h03;
  localparam logic [7:0] A_IMASK = 8'h04;
  localparam logic [7:0] A_ACK = 8'h05;
  localparam logic [7:0] A_HPEN = 8'h06;
  localparam logic [7:0] A_CFG = 8'h10;
  localparam logic [7:0] A_DUR = 8'h20;
  localparam logic [7:0] A_LFREQ = 8'h30;
  localparam logic [7:0] A_HFREQ = 8'h34;

  // Channel config fields
  localparam int CB_EN = 0;
  localparam int CB_MODE = 1;
  localparam int CB_SGL = 3;
  localparam int CB_FS = 4;
  localparam int CB_CHART = 5;
  localparam int CFG_W = 6;

  // Interrupt status fields
  localparam int IB_IN = 0;
  localparam int IB_OUT = 1;
  localparam int IB_FRQ = 2;
  localparam int IB_REJ = 3;
  localparam int IRQ_W = 4;

  typedef enum logic [1:0] {
    MODE_IN = 2'h0,
    MODE_OUT = 2'h1,
    MODE_PULSE = 2'h2
  } ardio_mode_t;

  typedef enum logic [1:0] {
    KIND_DIG8 = 2'h0,
    KIND_DIG16 = 2'h1,
    KIND_REL4 = 2'h2,
    KIND_REL8 = 2'h3
  } ardio_kind_t;

  localparam ardio_kind_t ARD_CARD_RST = KIND_DIG16;

endpackage : ardio_pkg

// *** rtl/ardio_top.sv ***
`timescale 1ns/1ps
// =====================================================================
// Alarm relay / digital IO card channel logic
// =====================================================================
module ardio_top
  import ardio_pkg::*;
#(
  parameter int NCH = ARD_NCH,
  parameter int TICK_CYC = ARD_TICK_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [ARD_AW-1:0] reg_addr,
  input wire logic [ARD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [ARD_DW-1:0] reg_rdata,
  input wire logic [NCH-1:0] alarm_in,
  input wire logic [NCH-1:0] io_i,
  output logic [NCH-1:0] io_o,
  output logic [NCH-1:0] io_oen,
  input wire logic [ARD_NPL-1:0] hp_i,
  output logic [NCH-1:0] evt_msg,
  output logic [NCH-1:0] evt_chart,
  output logic irq
);

  localparam int NPL = ARD_NPL;
  localparam int DIVW = $clog2(TICK_CYC + 1);

  typedef struct packed {
    ardio_kind_t card;
    logic [NCH-1:0][CFG_W-1:0] cfg;
    logic [NCH-1:0][15:0] dur;
    logic [NCH-1:0][15:0] tmr;
    logic [NCH-1:0] s1;
    logic [NCH-1:0] s2;
    logic [NCH-1:0] s3;
    logic [NCH-1:0] lvl;
    logic [NCH-1:0] trg;
    logic [NCH-1:0] ackd;
    logic [NCH-1:0] actp;
    logic [NCH-1:0] cont;
    logic [NCH-1:0] oen;
    logic [NCH-1:0] em;
    logic [NCH-1:0] ec;
    logic [NPL-1:0] hpen;
    logic [IRQ_W-1:0] ist;
    logic [IRQ_W-1:0] imsk;
    logic [DIVW-1:0] div;
    logic [3:0] tk;
    logic [ARD_DW-1:0] rdat;
  } ardio_st_t;

  ardio_st_t q, d;
  logic [NCH-1:0] outm, inm, act, sgl, fs, ack;
  logic [NPL-1:0] pls_en;
  logic [NPL-1:0][ARD_FW-1:0] lfreq, hfreq;
  logic tick, gate, evin, evout, rej;

  // Card population and mode legality per channel
  function automatic logic mode_ok(input ardio_kind_t kind, input int ch,
                                   input logic [1:0] m);
    logic ok;
    ok = 1'b0;
    unique case (kind)
      KIND_DIG8:
        ok = (ch < ARD_CH_DIG8) && (m != 2'h3) && (m != MODE_PULSE || ch < NPL);
      KIND_DIG16:
        ok = (ch < ARD_CH_DIG16) && (m != 2'h3) && (m != MODE_PULSE || ch < NPL);
      KIND_REL4:
        ok = (ch < ARD_CH_REL4) && (m == MODE_OUT);
      KIND_REL8:
        ok = (ch < ARD_CH_REL8) && (m == MODE_OUT ||
             (ch >= ARD_REL8_FIXED && m == MODE_IN));
    endcase
    return ok;
  endfunction : mode_ok

  // =================================================================
  // Next-state logic
  // =================================================================
  always_comb
  begin
    logic en_c;
    logic rise;
    int idx;
    en_c = 1'b0;
    rise = 1'b0;
    idx = 0;
    d = q;
    evin = 1'b0;
    evout = 1'b0;
    rej = 1'b0;
    outm = '0;
    inm = '0;
    act = '0;
    sgl = '0;
    fs = '0;
    pls_en = '0;
    // Tenth-second tick and one-second gate
    tick = (q.div == DIVW'(TICK_CYC - 1));
    gate = tick && (q.tk == 4'(ARD_GATE_TICKS - 1));
    d.div = tick ? '0 : q.div + 1'b1;
    if (tick)
      d.tk = gate ? 4'h0 : q.tk + 4'h1;
    ack = (reg_wr && reg_addr == A_ACK) ? NCH'(reg_wdata) : '0;
    // Three-stage pin sync
    d.s1 = io_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    for (int i = 0; i < NCH; i++)
    begin
      en_c = q.cfg[i][CB_EN] && mode_ok(q.card, i, q.cfg[i][CB_MODE +: 2]);
      outm[i] = en_c && q.cfg[i][CB_MODE +: 2] == MODE_OUT;
      inm[i] = en_c && q.cfg[i][CB_MODE +: 2] == MODE_IN;
      sgl[i] = q.cfg[i][CB_SGL];
      fs[i] = q.cfg[i][CB_FS];
      if (q.s2[i] == q.s3[i])
        d.lvl[i] = q.s2[i];
      // Trigger history and acknowledge latch
      d.trg[i] = alarm_in[i] && outm[i];
      rise = d.trg[i] && !q.trg[i];
      if (!d.trg[i])
        d.ackd[i] = 1'b0;
      else if (ack[i])
        d.ackd[i] = 1'b1;
      // Single-pulse timer in tenth-second steps
      if (!outm[i])
        d.tmr[i] = '0;
      else if (rise)
        d.tmr[i] = q.dur[i];
      else if (tick && q.tmr[i] != '0)
        d.tmr[i] = q.tmr[i] - 16'h0001;
      act[i] = outm[i] && (sgl[i] ? (q.tmr[i] != '0) : (q.trg[i] && !q.ackd[i]));
      d.actp[i] = act[i];
      d.cont[i] = outm[i] && (act[i] ^ fs[i]);
      d.oen[i] = !outm[i];
      // State-change events and their routing
      d.em[i] = (inm[i] && d.lvl[i] != q.lvl[i]) || (outm[i] && act[i] != q.actp[i]);
      d.ec[i] = d.em[i] && q.cfg[i][CB_CHART];
      evin = evin || (inm[i] && d.lvl[i] != q.lvl[i]);
      evout = evout || (outm[i] && act[i] != q.actp[i]);
    end
    for (int k = 0; k < NPL; k++)
    begin
      pls_en[k] = q.cfg[k][CB_EN] && q.cfg[k][CB_MODE +: 2] == MODE_PULSE &&
                  mode_ok(q.card, k, q.cfg[k][CB_MODE +: 2]);
    end
    // Register writes
    if (reg_wr)
    begin
      idx = int'(reg_addr[3:0]);
      if (reg_addr == A_CARD)
        d.card = ardio_kind_t'(reg_wdata[1:0]);
      if (reg_addr == A_IMASK)
        d.imsk = reg_wdata[IRQ_W-1:0];
      if (reg_addr == A_HPEN)
        d.hpen = reg_wdata[NPL-1:0];
      if (reg_addr[7:4] == A_CFG[7:4] && idx < NCH)
      begin
        if (mode_ok(q.card, idx, reg_wdata[CB_MODE +: 2]))
          d.cfg[idx] = reg_wdata[CFG_W-1:0];
        else
          rej = 1'b1;
      end
      if (reg_addr[7:4] == A_DUR[7:4] && idx < NCH)
      begin
        if (reg_wdata < ARD_DUR_MIN)
          d.dur[idx] = ARD_DUR_MIN;
        else if (reg_wdata > ARD_DUR_MAX)
          d.dur[idx] = ARD_DUR_MAX;
        else
          d.dur[idx] = reg_wdata;
      end
    end
    // Read mux, data valid the cycle after the strobe only
    d.rdat = '0;
    if (reg_rd)
    begin
      idx = int'(reg_addr[3:0]);
      if (reg_addr == A_CARD)
        d.rdat = ARD_DW'(q.card);
      else if (reg_addr == A_STATE)
        d.rdat = ARD_DW'(q.lvl & inm);
      else if (reg_addr == A_RELAY)
        d.rdat = ARD_DW'(act);
      else if (reg_addr == A_ISTAT)
        d.rdat = ARD_DW'(q.ist);
      else if (reg_addr == A_IMASK)
        d.rdat = ARD_DW'(q.imsk);
      else if (reg_addr == A_HPEN)
        d.rdat = ARD_DW'(q.hpen);
      else if (reg_addr[7:4] == A_CFG[7:4] && idx < NCH)
        d.rdat = ARD_DW'(q.cfg[idx]);
      else if (reg_addr[7:4] == A_DUR[7:4] && idx < NCH)
        d.rdat = q.dur[idx];
      else if (reg_addr[7:2] == A_LFREQ[7:2])
        d.rdat = lfreq[reg_addr[1:0]];
      else if (reg_addr[7:2] == A_HFREQ[7:2])
        d.rdat = hfreq[reg_addr[1:0]];
    end
    // Sticky status, read clears, new event wins
    d.ist = ((reg_rd && reg_addr == A_ISTAT) ? '0 : q.ist) |
            {rej, gate, evout, evin};
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      q <= '0;
      q.dur <= {NCH{ARD_DUR_MIN}}; // Shortest legal pulse until programmed
      q.oen <= '1;
      q.card <= ARD_CARD_RST;
    end
    else
      q <= d;
  end

  // =================================================================
  // Pulse counters: digital channels 0-3 and dedicated pulse pins
  // =================================================================
  for (genvar k = 0; k < NPL; k++)
  begin : g_pc
    ardio_pcnt #(.FW(ARD_FW)) u_lo (
      .clk(clk),
      .rstn(rstn),
      .pin(io_i[k]),
      .en(pls_en[k]),
      .gate(gate),
      .freq(lfreq[k])
    );
    ardio_pcnt #(.FW(ARD_FW)) u_hi (
      .clk(clk),
      .rstn(rstn),
      .pin(hp_i[k]),
      .en(q.hpen[k]),
      .gate(gate),
      .freq(hfreq[k])
    );
  end

  // Outputs
  assign io_o = q.cont;
  assign io_oen = q.oen;
  assign evt_msg = q.em;
  assign evt_chart = q.ec;
  assign reg_rdata = q.rdat;
  assign irq = |(q.ist & q.imsk);

  // =================================================================
  // Checks
  // =================================================================
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  property p_dis_off;
    1'b1 |=> (((io_o | ~io_oen) & ~$past(outm)) == '0);
  endproperty
  a_dis_off: assert property (p_dis_off) else $error("disabled channel drives");

  property p_dis_quiet;
    1'b1 |=> ((evt_msg & ~$past(outm | inm)) == '0);
  endproperty
  a_dis_quiet: assert property (p_dis_quiet) else $error("disabled channel reports");

  property p_card_pop;
    (q.card == KIND_REL4) |-> (inm == '0 && (outm >> ARD_CH_REL4) == '0);
  endproperty
  a_card_pop: assert property (p_card_pop) else $error("four-relay card misuse");

  property p_rel8_fixed;
    (q.card == KIND_REL8) |-> (inm[ARD_REL8_FIXED-1:0] == '0);
  endproperty
  a_rel8_fixed: assert property (p_rel8_fixed) else $error("fixed relay as input");

  property p_pls_rej;
    (reg_wr && reg_addr[7:4] == A_CFG[7:4] && reg_addr[3:0] >= 4'(NPL) &&
     reg_wdata[CB_MODE +: 2] == MODE_PULSE) |=> (q.ist[IB_REJ] && $stable(q.cfg));
  endproperty
  a_pls_rej: assert property (p_pls_rej) else $error("pulse mode not refused");

  property p_latch_drop;
    1'b1 |=> ((act & ~sgl & ~$past(alarm_in)) == '0);
  endproperty
  a_latch_drop: assert property (p_latch_drop) else $error("latched relay held");

  property p_ack_rel;
    (ack != '0) |=> ((act & ~sgl & $past(ack)) == '0);
  endproperty
  a_ack_rel: assert property (p_ack_rel) else $error("ack did not release");

  sequence s_arm;
    outm[2] && sgl[2] && alarm_in[2] && !q.trg[2];
  endsequence
  sequence s_fire;
    act[2] && q.tmr[2] == $past(q.dur[2]);
  endsequence

  property p_sp_fire;
    s_arm |=> s_fire;
  endproperty
  a_sp_fire: assert property (p_sp_fire) else $error("single pulse not started");

  property p_sp_once;
    ($rose(act[2]) && sgl[2]) |-> $past(alarm_in[2] && !q.trg[2]);
  endproperty
  a_sp_once: assert property (p_sp_once) else $error("pulse without alarm entry");

  property p_dur_rng;
    (reg_wr && reg_addr == A_DUR) |=> (q.dur[0] >= ARD_DUR_MIN && q.dur[0] <= ARD_DUR_MAX);
  endproperty
  a_dur_rng: assert property (p_dur_rng) else $error("duration out of range");

  property p_nofs;
    1'b1 |=> (((io_o ^ $past(act)) & $past(outm & ~fs)) == '0);
  endproperty
  a_nofs: assert property (p_nofs) else $error("contact wrong, failsafe off");

  property p_fs;
    1'b1 |=> (((io_o ^ ~$past(act)) & $past(outm & fs)) == '0);
  endproperty
  a_fs: assert property (p_fs) else $error("contact wrong, failsafe on");

  property p_route;
    1'b1 |-> ((evt_chart & ~evt_msg) == '0);
  endproperty
  a_route: assert property (p_route) else $error("chart event without message");

  property p_rst_idle;
    $past(!rstn) |-> (io_o == '0 && io_oen == '1 && evt_msg == '0);
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs active after reset");

endmodule : ardio_top

// *** verification/alarm_relay_digital_io_bench.sv ***
`timescale 1ns/1ps
// =====================================================================
// Bench for the alarm relay / digital IO channel logic
// =====================================================================
module alarm_relay_digital_io_bench
  import ardio_pkg::*;
;
  logic clk = 1'b0;
  logic rstn;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [15:0] reg_rdata;
  logic [15:0] alarm_in;
  logic [15:0] io_i;
  logic [15:0] io_o;
  logic [15:0] io_oen;
  logic [3:0] hp_i;
  logic [15:0] evt_msg;
  logic [15:0] evt_chart;
  logic irq;
  logic [15:0] contact;
  logic [7:0] lp_per;
  logic [7:0] hp_per;
  logic [15:0] msg_seen = 16'h0000;
  logic [15:0] chart_seen = 16'h0000;
  logic seen_clr = 1'b0;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  // Card table: kind, channel, config word, accepted
  logic [1:0] tk [6] = '{2'h2, 2'h2, 2'h3, 2'h3, 2'h0, 2'h1};
  int tc [6] = '{0, 1, 5, 6, 2, 4};
  logic [15:0] tv [6] = '{16'h0001, 16'h0003, 16'h0001, 16'h0001, 16'h0005, 16'h0005};
  logic ta [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};

  always #50 clk = ~clk;

  ardio_top #(.NCH(16), .TICK_CYC(10)) ardio_top_inst (.clk(clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .alarm_in(alarm_in), .io_i(io_i), .io_o(io_o),
    .io_oen(io_oen), .hp_i(hp_i), .evt_msg(evt_msg), .evt_chart(evt_chart), .irq(irq));

  ardio_field ardio_field_inst (.clk(clk), .io_o(io_o), .io_oen(io_oen),
    .contact(contact), .lp_per(lp_per), .hp_per(hp_per), .io_i(io_i), .hp_i(hp_i));

  // =================================================================
  // Event capture and hang guard
  // =================================================================
  always @(posedge clk)
  begin
    // Capture is cleared in reset, before the outputs are known
    if (!rstn || seen_clr)
    begin
      msg_seen <= 16'h0000;
      chart_seen <= 16'h0000;
    end
    else
    begin
      msg_seen <= msg_seen | evt_msg;
      chart_seen <= chart_seen | evt_chart;
    end
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  // =================================================================
  // Tasks
  // =================================================================
  task end_of_test();
    $display("Compared %0d values, %0d mismatches", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test

  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr

  task rd(input string n, input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(n, e, reg_rdata & m);
  endtask : rd

  task rst();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
  endtask : rst

  task alarm(input logic [15:0] v);
    @(posedge clk);
    alarm_in <= v;
  endtask : alarm

  // =================================================================
  // Main sequence
  // =================================================================
  initial
  begin
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    alarm_in = 16'h0000;
    contact = 16'h0000;
    lp_per = 8'h00;
    hp_per = 8'h00;
    rst();
    #1;
    chk("io_oen", 16'hffff, io_oen);
    chk("io_o", 16'h0000, io_o);
    chk("irq", 16'h0000, irq);
    rd("card", A_CARD, 16'h0003, 16'h0001);
    rd("unmapped", 8'h7f, 16'hffff, 16'h0000);
    rd("hfreq", A_HFREQ, 16'hffff, 16'h0000);
    // Latched ch0, failsafe ch1, single pulse ch2, disabled ch3
    wr(A_CFG, 16'h0003);
    wr(A_CFG + 8'h01, 16'h0013);
    wr(A_CFG + 8'h02, 16'h000b);
    wr(A_DUR + 8'h02, 16'h0003);
    cyc(3);
    chk("idle pins", 16'h0002, io_o[3:0]);
    chk("idle oen", 16'h0008, io_oen[3:0]);
    alarm(16'h000b);
    cyc(3);
    chk("alarm pins", 16'h0001, io_o[3:0]);
    chk("disabled evt", 16'h0000, msg_seen[3]);
    cyc(20);
    chk("latched hold", 16'h0001, io_o[0]);
    wr(A_ACK, 16'h0001);
    cyc(3);
    chk("ack release", 16'h0000, io_o[0]);
    alarm(16'h0000);
    cyc(3);
    alarm(16'h0001);
    cyc(3);
    chk("relatch", 16'h0001, io_o[0]);
    alarm(16'h0000);
    cyc(3);
    chk("clear drop", 16'h0002, io_o[3:0]);
    // Single pulse of 3 ticks while alarm stays high
    alarm(16'h0004);
    cyc(5);
    chk("pulse on", 16'h0001, io_o[2]);
    cyc(30);
    chk("pulse off", 16'h0000, io_o[2]);
    cyc(40);
    chk("no retrigger", 16'h0000, io_o[2]);
    alarm(16'h0000);
    cyc(2);
    alarm(16'h0004);
    cyc(5);
    chk("retrigger", 16'h0001, io_o[2]);
    alarm(16'h0000);
    wr(A_DUR, 16'h0000);
    rd("dur min", A_DUR, 16'hffff, ARD_DUR_MIN);
    wr(A_DUR, 16'hffff);
    rd("dur max", A_DUR, 16'hffff, ARD_DUR_MAX);
    // Inputs with chart on ch5, messages only on ch6, ch7 disabled
    wr(A_CFG + 8'h05, 16'h0021);
    wr(A_CFG + 8'h06, 16'h0001);
    wr(A_IMASK, 16'h0001);
    rd("clear", A_ISTAT, 16'hfff0, 16'h0000);
    cyc(8);
    seen_clr <= 1'b1;
    @(posedge clk);
    seen_clr <= 1'b0;
    contact <= 16'h00e0;
    cyc(10);
    chk("msg evt", 16'h0003, msg_seen[7:5]);
    chk("chart evt", 16'h0001, chart_seen[7:5]);
    chk("irq set", 16'h0001, irq);
    rd("state", A_STATE, 16'h00e0, 16'h0060);
    rd("istat", A_ISTAT, 16'h0001, 16'h0001);
    chk("irq clear", 16'h0000, irq);
    // Card kinds and pulse mode placement
    rst();
    for (int i = 0; i < 6; i++)
    begin
      wr(A_CARD, {14'h0000, tk[i]});
      rd("clear", A_ISTAT, 16'hfff0, 16'h0000);
      wr(A_CFG + 8'(tc[i]), tv[i]);
      rd("cfg", A_CFG + 8'(tc[i]), 16'h003f, ta[i] ? tv[i] : 16'h0000);
      rd("refused", A_ISTAT, 16'h0008, ta[i] ? 16'h0000 : 16'h0008);
    end
    // Frequency counting on ch2 of an 8-channel card and dedicated pin 0
    wr(A_CARD, 16'h0000);
    wr(A_HPEN, 16'h0001);
    @(posedge clk);
    lp_per <= 8'd20;
    hp_per <= 8'd10;
    rd("clear", A_ISTAT, 16'hfff0, 16'h0000);
    cyc(250);
    rd("lfreq", A_LFREQ + 8'h02, 16'hffff, 16'd5);
    rd("hfreq", A_HFREQ, 16'hffff, 16'd10);
    rd("hfreq off", A_HFREQ + 8'h01, 16'hffff, 16'h0000);
    rd("gate evt", A_ISTAT, 16'h0004, 16'h0004);
    end_of_test();
  end
endmodule : alarm_relay_digital_io_bench

// *** verification/ardio_field.sv ***
`timescale 1ns/1ps
// =====================================================================
// Field side model: contacts, pulse sources and pin wires
// =====================================================================
module ardio_field
(
  input wire logic clk,
  input wire logic [15:0] io_o,
  input wire logic [15:0] io_oen,
  input wire logic [15:0] contact,
  input wire logic [7:0] lp_per,
  input wire logic [7:0] hp_per,
  output logic [15:0] io_i,
  output logic [3:0] hp_i
);
  logic [7:0] lp_cnt = 8'h00;
  logic [7:0] hp_cnt = 8'h00;
  logic lp_wave;

  // Pulse sources, held still while their period is zero
  always @(posedge clk)
  begin
    lp_cnt <= (lp_cnt + 8'h01 >= lp_per) ? 8'h00 : lp_cnt + 8'h01;
    hp_cnt <= (hp_cnt + 8'h01 >= hp_per) ? 8'h00 : hp_cnt + 8'h01;
  end
  assign lp_wave = (lp_per != 8'h00) && (lp_cnt < (lp_per >> 1));
  assign hp_i = {4{(hp_per != 8'h00) && (hp_cnt < (hp_per >> 1))}};

  // Wire level: the card wins while its enable is low, else the field side
  always_comb
  begin
    for (int k = 0; k < 16; k++)
    begin
      io_i[k] = io_oen[k] ? contact[k] : io_o[k];
      if (k < 4 && io_oen[k] && lp_per != 8'h00)
        io_i[k] = lp_wave;
    end
  end
endmodule : ardio_field
